// File: src/ipcoc_consts.vh
// Constants for the IR pixel calibration and offset compensation block
// Functional notes
// - Pixel offset delta byte comes from EEPROM 0x00-0x3F, unsigned.
// - Pixel offset slope byte comes from EEPROM 0x40-0x7F, two's complement.
// - Per-pixel bytes use the pixel index as offset in each pixel region.
// - Sensitivity slope exponent is byte 0xC0 low nibble; high nibble ignored.
// - Sensitivity object slope is signed byte at 0xC4.
// - Sensitivity slope divides by two to the nibble plus eight.
// - Common offset is signed 16 bits from 0xD0 low, 0xD1 high.
// - Gradient pixel offset is signed 16 bits from 0xD3 low, 0xD4 high.
// - Gradient pixel offset slope is signed byte at 0xD5.
// - Gradient pixel sensitivity is unsigned from 0xD6 low, 0xD7 high.
// - Byte 0xD9 high nibble scales the pixel offset delta.
// - Byte 0xD9 low nibble divides both offset slopes.
// - Shared pixel sensitivity is unsigned from 0xE0 low, 0xE1 high.
// - Shared sensitivity exponent is unsigned byte 0xE2.
// - Pixel sensitivity delta exponent is unsigned byte 0xE3.
// - Ambient sensitivity slope is signed 16 bits 0xE6/0xE7, exponent 20.
// - Object temperature needs ambient Kelvin; offset 273.15 degrees.
// - Pixel offset is common plus scaled delta, divided by 2^(3-resolution).
// - Gradient pixel uses same offset compensation and same slope exponent.
// - Gradient coefficient is signed byte divided by 32, scales gradient signal.
// - Emissivity is 16 bits over 32768; gradient-compensated signal divided by it.
`ifndef IPCOC_CONSTS_VH
`define IPCOC_CONSTS_VH
`define IPCOC_EE_DELTA_BASE 8'h00
`define IPCOC_EE_SLOPE_BASE 8'h40
`define IPCOC_EE_DSENS_BASE 8'h80
`define IPCOC_EE_SENS_SCALE 8'hC0
`define IPCOC_EE_SENS_OBJ 8'hC4
`define IPCOC_EE_COMMON_L 8'hD0
`define IPCOC_EE_COMMON_H 8'hD1
`define IPCOC_EE_GRAD_OFS_L 8'hD3
`define IPCOC_EE_GRAD_OFS_H 8'hD4
`define IPCOC_EE_GRAD_SLOPE 8'hD5
`define IPCOC_EE_GRAD_SENS_L 8'hD6
`define IPCOC_EE_GRAD_SENS_H 8'hD7
`define IPCOC_EE_GRAD_COEF 8'hD8
`define IPCOC_EE_SCALES 8'hD9
`define IPCOC_EE_SHARED_L 8'hE0
`define IPCOC_EE_SHARED_H 8'hE1
`define IPCOC_EE_SHARED_EXP 8'hE2
`define IPCOC_EE_DSENS_EXP 8'hE3
`define IPCOC_EE_EMISS_L 8'hE4
`define IPCOC_EE_EMISS_H 8'hE5
`define IPCOC_EE_AMBSLOPE_L 8'hE6
`define IPCOC_EE_AMBSLOPE_H 8'hE7
`define IPCOC_FETCH_LAST 5'd21
`define IPCOC_SENS_EXP_BIAS 5'd8
`define IPCOC_AMBSLOPE_EXP 8'h14
`define IPCOC_GRAD_COEF_SHIFT 6'h05
`define IPCOC_EMISS_SHIFT 7'h0F
`define IPCOC_FRAC 5'h10
`define IPCOC_Q8_TO_Q16 5'h08
`define IPCOC_REF_AMB 17'h01900
`define IPCOC_KELVIN_Q8 24'h011126
`define IPCOC_RES_MAX 2'h3
`define IPCOC_REG_CTRL 8'h00
`define IPCOC_REG_PIXEL_IDX 8'h04
`define IPCOC_REG_PIX_RAW 8'h08
`define IPCOC_REG_GRAD_RAW 8'h0C
`define IPCOC_REG_AMBIENT 8'h10
`define IPCOC_REG_STATUS 8'h14
`define IPCOC_REG_PIX_OC 8'h18
`define IPCOC_REG_GRAD_OC 8'h1C
`define IPCOC_REG_PIX_GRAD 8'h20
`define IPCOC_REG_PIX_COMP 8'h24
`define IPCOC_REG_OFFSETS 8'h28
`define IPCOC_REG_SENS 8'h2C
`define IPCOC_REG_EXPS 8'h30
`define IPCOC_REG_SLOPES 8'h34
`define IPCOC_REG_AMBSLOPE 8'h38
`define IPCOC_REG_EMISS 8'h3C
`define IPCOC_REG_KELVIN 8'h40
`define IPCOC_CTRL_START 0
`define IPCOC_CTRL_RES_LSB 4
`define IPCOC_RESP_OKAY 2'h0
`define IPCOC_RESP_SLVERR 2'h2
`endif

// File: src/ipcoc_offset_comp.v
// Offset compensation of one readout against offset and ambient slope
`include "ipcoc_consts.vh"
module ipcoc_offset_comp (
  input wire [15:0] raw_i,
  input wire [15:0] base_i,
  input wire [7:0] delta_i,
  input wire [3:0] delta_exp_i,
  input wire [7:0] slope_i,
  input wire [3:0] slope_exp_i,
  input wire [1:0] res_i,
  input wire [15:0] amb_i,
  output wire [47:0] oc_o
);
  // All terms carried as Q.16 so fractional slopes are not lost
  wire [1:0] res_shift = `IPCOC_RES_MAX - res_i;
  wire signed [47:0] raw_w = $signed(raw_i);
  wire signed [47:0] base_w = $signed(base_i);
  wire [47:0] delta_w = {40'h0000000000, delta_i};
  wire [4:0] delta_sh = {1'b0, delta_exp_i} + `IPCOC_FRAC;
  wire [47:0] delta_q = delta_w << delta_sh;
  wire signed [47:0] a_q = ((base_w <<< `IPCOC_FRAC) + $signed(delta_q)) >>> res_shift;
  wire signed [16:0] amb_d = $signed({amb_i[15], amb_i}) - $signed(`IPCOC_REF_AMB);
  wire signed [24:0] prod = $signed(slope_i) * amb_d;
  wire signed [47:0] prod_w = prod;
  wire [4:0] slope_sh = {1'b0, slope_exp_i} + {3'h0, res_shift};
  wire signed [47:0] b_q = (prod_w <<< `IPCOC_Q8_TO_Q16) >>> slope_sh;
  assign oc_o = (raw_w <<< `IPCOC_FRAC) - a_q - b_q;
endmodule

// File: src/ipcoc_serial_div.v
// Serial restoring divider, one quotient bit per enabled clock
module ipcoc_serial_div #(
  parameter NW = 64,
  parameter DW = 16
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire start_i,
  input wire [NW-1:0] num_i,
  input wire [DW-1:0] den_i,
  output reg [NW-1:0] quo_o,
  output reg done_o
);
  localparam CW = $clog2(NW + 1);
  reg [DW:0] rem;
  reg [DW-1:0] den;
  reg [CW-1:0] cnt;
  // Zero divisor gives an all-ones quotient; no trap is raised
  wire [DW:0] trial = {rem[DW-1:0], quo_o[NW-1]};
  wire fits = trial >= {1'b0, den};
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rem <= {(DW+1){1'b0}};
      den <= {DW{1'b0}};
      cnt <= {CW{1'b0}};
      quo_o <= {NW{1'b0}};
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        rem <= {(DW+1){1'b0}};
        den <= den_i;
        quo_o <= num_i;
        cnt <= NW[CW-1:0];
      end else if (cnt != {CW{1'b0}}) begin
        rem <= fits ? trial - {1'b0, den} : trial;
        quo_o <= {quo_o[NW-2:0], fits};
        cnt <= cnt - 1'b1;
        done_o <= (cnt == {{(CW-1){1'b0}}, 1'b1});
      end
    end
  end
endmodule

// File: src/ipcoc_top.v
// IR pixel calibration fetch, coefficient decode and offset compensation
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`include "ipcoc_consts.vh"
module ipcoc_top (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  output reg [7:0] ee_addr_o,
  output reg ee_rd_o,
  input wire [7:0] ee_data_i,
  input wire ee_valid_i
);
  localparam S_IDLE = 2'b00;
  localparam S_FETCH = 2'b01;
  localparam S_CALC = 2'b10;
  localparam S_DIV = 2'b11;

  ////////////////////////////////////////////////////////////////////////////
  // Host-written settings
  reg [1:0] adc_resolution_setting;
  reg [5:0] pixel_index;
  reg [15:0] pixel_readout;
  reg [15:0] gradient_pixel_readout;
  reg [15:0] ambient_temperature;
  reg start_req;
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;

  // State of the computation
  reg [1:0] state;
  reg [4:0] step;
  reg done_flag;
  reg [7:0] ee_byte [0:255];
  reg signed [47:0] pix_oc;
  reg signed [47:0] grad_oc;
  reg signed [47:0] pix_grad;
  reg [31:0] pix_comp;
  reg comp_neg;
  reg div_start;
  wire [63:0] div_quo;
  wire div_done;

  function [31:0] merge_bytes(input [31:0] old, input [31:0] nw, input [3:0] strb);
    integer k;
    begin
      merge_bytes = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge_bytes[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // Fetch order: three per-pixel bytes, then the shared calibration bytes
  function [7:0] fetch_addr(input [4:0] s, input [5:0] idx);
    begin
      case (s)
        5'd0: fetch_addr = `IPCOC_EE_DELTA_BASE + {2'b00, idx};
        5'd1: fetch_addr = `IPCOC_EE_SLOPE_BASE + {2'b00, idx};
        5'd2: fetch_addr = `IPCOC_EE_DSENS_BASE + {2'b00, idx};
        5'd3: fetch_addr = `IPCOC_EE_SENS_SCALE;
        5'd4: fetch_addr = `IPCOC_EE_SENS_OBJ;
        5'd5: fetch_addr = `IPCOC_EE_COMMON_L;
        5'd6: fetch_addr = `IPCOC_EE_COMMON_H;
        5'd7: fetch_addr = `IPCOC_EE_GRAD_OFS_L;
        5'd8: fetch_addr = `IPCOC_EE_GRAD_OFS_H;
        5'd9: fetch_addr = `IPCOC_EE_GRAD_SLOPE;
        5'd10: fetch_addr = `IPCOC_EE_GRAD_SENS_L;
        5'd11: fetch_addr = `IPCOC_EE_GRAD_SENS_H;
        5'd12: fetch_addr = `IPCOC_EE_GRAD_COEF;
        5'd13: fetch_addr = `IPCOC_EE_SCALES;
        5'd14: fetch_addr = `IPCOC_EE_SHARED_L;
        5'd15: fetch_addr = `IPCOC_EE_SHARED_H;
        5'd16: fetch_addr = `IPCOC_EE_SHARED_EXP;
        5'd17: fetch_addr = `IPCOC_EE_DSENS_EXP;
        5'd18: fetch_addr = `IPCOC_EE_EMISS_L;
        5'd19: fetch_addr = `IPCOC_EE_EMISS_H;
        5'd20: fetch_addr = `IPCOC_EE_AMBSLOPE_L;
        default: fetch_addr = `IPCOC_EE_AMBSLOPE_H;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decoded coefficients
  wire [7:0] pixel_offset_delta = ee_byte[`IPCOC_EE_DELTA_BASE + {2'b00, pixel_index}];
  wire [7:0] pixel_offset_slope = ee_byte[`IPCOC_EE_SLOPE_BASE + {2'b00, pixel_index}];
  wire [7:0] pixel_sensitivity_delta = ee_byte[`IPCOC_EE_DSENS_BASE + {2'b00, pixel_index}];
  wire [4:0] sensitivity_slope_exponent =
    {1'b0, ee_byte[`IPCOC_EE_SENS_SCALE][3:0]} + `IPCOC_SENS_EXP_BIAS;
  wire [7:0] sensitivity_object_slope = ee_byte[`IPCOC_EE_SENS_OBJ];
  wire [15:0] common_offset =
    {ee_byte[`IPCOC_EE_COMMON_H], ee_byte[`IPCOC_EE_COMMON_L]};
  wire [15:0] gradient_pixel_offset =
    {ee_byte[`IPCOC_EE_GRAD_OFS_H], ee_byte[`IPCOC_EE_GRAD_OFS_L]};
  wire [7:0] gradient_pixel_offset_slope = ee_byte[`IPCOC_EE_GRAD_SLOPE];
  wire [15:0] gradient_pixel_sensitivity =
    {ee_byte[`IPCOC_EE_GRAD_SENS_H], ee_byte[`IPCOC_EE_GRAD_SENS_L]};
  wire [7:0] thermal_gradient_coefficient = ee_byte[`IPCOC_EE_GRAD_COEF];
  wire [3:0] offset_delta_exponent = ee_byte[`IPCOC_EE_SCALES][7:4];
  wire [3:0] offset_slope_exponent = ee_byte[`IPCOC_EE_SCALES][3:0];
  wire [15:0] shared_pixel_sensitivity =
    {ee_byte[`IPCOC_EE_SHARED_H], ee_byte[`IPCOC_EE_SHARED_L]};
  wire [7:0] shared_sensitivity_exponent = ee_byte[`IPCOC_EE_SHARED_EXP];
  wire [7:0] sensitivity_delta_exponent = ee_byte[`IPCOC_EE_DSENS_EXP];
  wire [15:0] emissivity = {ee_byte[`IPCOC_EE_EMISS_H], ee_byte[`IPCOC_EE_EMISS_L]};
  wire [15:0] sensitivity_ambient_slope =
    {ee_byte[`IPCOC_EE_AMBSLOPE_H], ee_byte[`IPCOC_EE_AMBSLOPE_L]};
  // Kelvin ambient is handed to software, which takes the fourth root
  wire [23:0] ambient_kelvin =
    {{8{ambient_temperature[15]}}, ambient_temperature} + `IPCOC_KELVIN_Q8;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  wire [47:0] pix_oc_w;
  wire [47:0] grad_oc_w;
  ipcoc_offset_comp u_pix_oc (
    .raw_i(pixel_readout),
    .base_i(common_offset),
    .delta_i(pixel_offset_delta),
    .delta_exp_i(offset_delta_exponent),
    .slope_i(pixel_offset_slope),
    .slope_exp_i(offset_slope_exponent),
    .res_i(adc_resolution_setting),
    .amb_i(ambient_temperature),
    .oc_o(pix_oc_w)
  );
  // Same path for the gradient pixel, no delta, same slope exponent
  ipcoc_offset_comp u_grad_oc (
    .raw_i(gradient_pixel_readout),
    .base_i(gradient_pixel_offset),
    .delta_i(8'h00),
    .delta_exp_i(4'h0),
    .slope_i(gradient_pixel_offset_slope),
    .slope_exp_i(offset_slope_exponent),
    .res_i(adc_resolution_setting),
    .amb_i(ambient_temperature),
    .oc_o(grad_oc_w)
  );
  wire signed [55:0] grad_prod = $signed(thermal_gradient_coefficient) * $signed(grad_oc_w);
  wire signed [55:0] grad_term = grad_prod >>> `IPCOC_GRAD_COEF_SHIFT;
  wire signed [47:0] pix_grad_w = $signed(pix_oc_w) - grad_term[47:0];
  wire [47:0] pix_grad_mag = pix_grad_w[47] ? -pix_grad_w : pix_grad_w;
  wire [63:0] div_num = {16'h0000, pix_grad_mag} << `IPCOC_EMISS_SHIFT;
  wire [31:0] div_q32 = div_quo[31:0];

  ipcoc_serial_div #(
    .NW(64),
    .DW(16)
  ) u_div (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .start_i(div_start),
    .num_i(div_num),
    .den_i(emissivity),
    .quo_o(div_quo),
    .done_o(div_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: fetch, compute, divide
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= S_IDLE;
      step <= 5'd0;
      done_flag <= 1'b0;
      ee_addr_o <= 8'h00;
      ee_rd_o <= 1'b0;
      pix_oc <= 48'h000000000000;
      grad_oc <= 48'h000000000000;
      pix_grad <= 48'h000000000000;
      pix_comp <= 32'h00000000;
      comp_neg <= 1'b0;
      div_start <= 1'b0;
    end else if (ce_i) begin
      div_start <= 1'b0;
      case (state)
        S_IDLE: begin
          // Inputs are used live, so the host holds them while busy
          if (start_req) begin
            done_flag <= 1'b0;
            step <= 5'd0;
            ee_addr_o <= fetch_addr(5'd0, pixel_index);
            ee_rd_o <= 1'b1;
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          // One byte at a time; the store may answer after any delay
          if (!ee_rd_o) begin
            ee_addr_o <= fetch_addr(step, pixel_index);
            ee_rd_o <= 1'b1;
          end else if (ee_valid_i) begin
            ee_rd_o <= 1'b0;
            if (step == `IPCOC_FETCH_LAST) begin
              state <= S_CALC;
            end else begin
              step <= step + 5'd1;
            end
          end
        end
        S_CALC: begin
          pix_oc <= pix_oc_w;
          grad_oc <= grad_oc_w;
          pix_grad <= pix_grad_w;
          comp_neg <= pix_grad_w[47];
          div_start <= 1'b1;
          state <= S_DIV;
        end
        default: begin
          if (div_done) begin
            pix_comp <= comp_neg ? -div_q32 : div_q32;
            done_flag <= 1'b1;
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Byte store has no reset; only the 22 fetched bytes are valid after a fetch
  always @(posedge clk_sys_i) begin
    if (ce_i && state == S_FETCH && ee_rd_o && ee_valid_i) begin
      ee_byte[ee_addr_o] <= ee_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode
  reg rd_hit;
  reg [31:0] rd_word;
  always @* begin
    rd_hit = 1'b1;
    rd_word = 32'h00000000;
    case (s_axi_araddr_i)
      `IPCOC_REG_CTRL: rd_word = {26'h0000000, adc_resolution_setting, 4'h0};
      `IPCOC_REG_PIXEL_IDX: rd_word = {26'h0000000, pixel_index};
      `IPCOC_REG_PIX_RAW: rd_word = {16'h0000, pixel_readout};
      `IPCOC_REG_GRAD_RAW: rd_word = {16'h0000, gradient_pixel_readout};
      `IPCOC_REG_AMBIENT: rd_word = {16'h0000, ambient_temperature};
      `IPCOC_REG_STATUS: rd_word = {30'h00000000, done_flag, state != S_IDLE};
      `IPCOC_REG_PIX_OC: rd_word = pix_oc[31:0];
      `IPCOC_REG_GRAD_OC: rd_word = grad_oc[31:0];
      `IPCOC_REG_PIX_GRAD: rd_word = pix_grad[31:0];
      `IPCOC_REG_PIX_COMP: rd_word = pix_comp;
      `IPCOC_REG_OFFSETS: rd_word = {gradient_pixel_offset, common_offset};
      `IPCOC_REG_SENS: rd_word = {gradient_pixel_sensitivity, shared_pixel_sensitivity};
      `IPCOC_REG_EXPS: rd_word = {3'h0, sensitivity_slope_exponent,
        sensitivity_delta_exponent, shared_sensitivity_exponent,
        offset_slope_exponent, offset_delta_exponent};
      `IPCOC_REG_SLOPES: rd_word = {pixel_offset_slope, thermal_gradient_coefficient,
        gradient_pixel_offset_slope, sensitivity_object_slope};
      `IPCOC_REG_AMBSLOPE: rd_word = {`IPCOC_AMBSLOPE_EXP, pixel_sensitivity_delta,
        sensitivity_ambient_slope};
      `IPCOC_REG_EMISS: rd_word = {16'h0000, emissivity};
      `IPCOC_REG_KELVIN: rd_word = {8'h00, ambient_kelvin};
      default: rd_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  wire [31:0] ctrl_old = {26'h0000000, adc_resolution_setting, 4'h0};
  wire [31:0] ctrl_new = merge_bytes(ctrl_old, w_data, w_strb);
  wire [31:0] idx_new = merge_bytes({26'h0000000, pixel_index}, w_data, w_strb);
  wire [31:0] praw_new = merge_bytes({16'h0000, pixel_readout}, w_data, w_strb);
  wire [31:0] graw_new = merge_bytes({16'h0000, gradient_pixel_readout}, w_data, w_strb);
  wire [31:0] amb_new = merge_bytes({16'h0000, ambient_temperature}, w_data, w_strb);

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `IPCOC_RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= `IPCOC_RESP_OKAY;
      s_axi_rdata_o <= 32'h00000000;
      aw_addr <= 8'h00;
      aw_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      w_held <= 1'b0;
      start_req <= 1'b0;
      adc_resolution_setting <= `IPCOC_RES_MAX;
      pixel_index <= 6'h00;
      pixel_readout <= 16'h0000;
      gradient_pixel_readout <= 16'h0000;
      ambient_temperature <= 16'h0000;
    end else if (ce_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_arready_o <= 1'b0;
      start_req <= 1'b0;
      if (s_axi_awvalid_i && !s_axi_awready_o && !aw_held) begin
        s_axi_awready_o <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        aw_held <= 1'b1;
      end
      if (s_axi_wvalid_i && !s_axi_wready_o && !w_held) begin
        s_axi_wready_o <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        w_held <= 1'b1;
      end
      if (aw_held && w_held && !s_axi_bvalid_o) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= `IPCOC_RESP_OKAY;
        case (aw_addr)
          `IPCOC_REG_CTRL: begin
            adc_resolution_setting <= ctrl_new[`IPCOC_CTRL_RES_LSB +: 2];
            // Start while busy is dropped, not queued
            start_req <= ctrl_new[`IPCOC_CTRL_START] && state == S_IDLE;
          end
          `IPCOC_REG_PIXEL_IDX: pixel_index <= idx_new[5:0];
          `IPCOC_REG_PIX_RAW: pixel_readout <= praw_new[15:0];
          `IPCOC_REG_GRAD_RAW: gradient_pixel_readout <= graw_new[15:0];
          `IPCOC_REG_AMBIENT: ambient_temperature <= amb_new[15:0];
          `IPCOC_REG_STATUS, `IPCOC_REG_PIX_OC, `IPCOC_REG_GRAD_OC,
          `IPCOC_REG_PIX_GRAD, `IPCOC_REG_PIX_COMP, `IPCOC_REG_OFFSETS,
          `IPCOC_REG_SENS, `IPCOC_REG_EXPS, `IPCOC_REG_SLOPES,
          `IPCOC_REG_AMBSLOPE, `IPCOC_REG_EMISS, `IPCOC_REG_KELVIN: begin
            s_axi_bresp_o <= `IPCOC_RESP_OKAY;
          end
          default: s_axi_bresp_o <= `IPCOC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o) begin
        s_axi_arready_o <= 1'b1;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_word;
        s_axi_rresp_o <= rd_hit ? `IPCOC_RESP_OKAY : `IPCOC_RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end
endmodule

// File: tb/ipcoc_monitor.sv
// Port checker for the calibration fetch and offset compensation block
module ipcoc_monitor (
  input logic clk_sys_i,
  input logic rst_n_i,
  input logic ce_i,
  input logic s_axi_awready_o,
  input logic s_axi_wready_o,
  input logic [1:0] s_axi_bresp_o,
  input logic s_axi_bvalid_o,
  input logic s_axi_bready_i,
  input logic s_axi_arvalid_i,
  input logic s_axi_arready_o,
  input logic [31:0] s_axi_rdata_o,
  input logic [1:0] s_axi_rresp_o,
  input logic s_axi_rvalid_o,
  input logic s_axi_rready_i,
  input logic [7:0] ee_addr_o,
  input logic ee_rd_o,
  input logic ee_valid_i
);
  // Frozen cycles prove nothing, so they are left out
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i || !ce_i);
  a_ee_hold: assert property (ee_rd_o && !ee_valid_i |=> ee_rd_o && $stable(ee_addr_o))
    else $error("byte address moved while waiting");
  a_ee_drop: assert property (ee_rd_o && ee_valid_i |=> !ee_rd_o)
    else $error("byte request not dropped");
  a_ee_region_step: assert property (
    ee_rd_o && ee_valid_i && ee_addr_o < 8'h80 |->
    ##2 ee_rd_o && ee_addr_o == $past(ee_addr_o, 2) + 8'h40)
    else $error("per-pixel region order broken");
  a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read data dropped early");
  a_b_answer: assert property (s_axi_awready_o && s_axi_wready_o |=> s_axi_bvalid_o)
    else $error("write response late");
  a_ar_answer: assert property (s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o
    |=> s_axi_arready_o && s_axi_rvalid_o)
    else $error("read answer late");
  a_aw_pulse: assert property (s_axi_awready_o |=> !s_axi_awready_o)
    else $error("write address ready too long");
  a_r_err_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o == 2'h2 |->
    s_axi_rdata_o == 32'h0)
    else $error("error read carries data");
endmodule
bind ipcoc_top ipcoc_monitor u_mon (.*);

// File: tb/ipcoc_ee_model.sv
// Calibration byte store answering after a chosen delay
module ipcoc_ee_model (
  input wire clk_sys_i,
  input wire [31:0] dly_i,
  input wire [7:0] addr_i,
  input wire rd_i,
  output logic [7:0] data_o,
  output logic valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  int cnt = 0;
  initial begin
    data_o = 8'h00;
    valid_o = 1'b0;
  end
  always @(posedge clk_sys_i) begin
    if (rd_i && !valid_o && cnt >= dly_i) begin
      valid_o <= 1'b1;
      data_o <= mem[addr_i];
      cnt <= 0;
    end else begin
      valid_o <= 1'b0;
      // Released bus inverts every cycle, so the last byte returns every other cycle
      data_o <= ~data_o;
      cnt <= rd_i ? cnt + 1 : 0;
    end
  end
endmodule

// File: tb/ipcoc_top_tb.sv
// Self-checking bench for the calibration fetch and offset compensation block
module ipcoc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 0, rst_n_i = 0, ce_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
  logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic [7:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, q;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic [1:0] rsp;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  wire [7:0] ee_addr_o, ee_data_i;
  wire ee_rd_o, ee_valid_i;
  int mismatches = 0, total_checks = 0, dly = 0, i;
  logic [7:0] seen [$];
  // Store contents for pixel 0x22, listed in fetch order
  logic [15:0] ee [22] = '{16'h2221, 16'h62BC, 16'hA2CD, 16'hC099, 16'hC49E, 16'hD08A,
    16'hD1FF, 16'hD39D, 16'hD4FF, 16'hD5A2, 16'hD6A8, 16'hD70F, 16'hD818, 16'hD907,
    16'hE0AE, 16'hE14E, 16'hE226, 16'hE31F, 16'hE400, 16'hE580, 16'hE60C, 16'hE702};
  logic [7:0] ra [11] = '{8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34,
    8'h38, 8'h3C, 8'h40};
  logic [31:0] rv [11] = '{32'h020D1000, 32'h00407800, 32'h01DCB600, 32'h01DCB600,
    32'hFF9DFF8A, 32'h0FA84EAE, 32'h111F2670, 32'hBC18A29E, 32'h14CD020C,
    32'h00008000, 32'h00012C26};
  ipcoc_top u_dut (.*);
  ipcoc_ee_model u_ee (.clk_sys_i(clk_sys_i), .dly_i(dly), .addr_i(ee_addr_o),
    .rd_i(ee_rd_o), .data_o(ee_data_i), .valid_o(ee_valid_i));
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (ee_rd_o && ee_valid_i) seen.push_back(ee_addr_o);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    @(posedge clk_sys_i);
  endtask
  task automatic run(input logic [31:0] ctrl);
    seen.delete();
    wr(8'h00, ctrl, 2'h0);
    // Waits for done; only the watchdog ends a hang
    do begin
      rd(8'h14, q, rsp);
    end while (q[1] !== 1'b1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #300us;
    mismatches++;
    report_and_stop;
  end
  initial begin
    for (i = 0; i < 22; i++) u_ee.mem[ee[i][15:8]] = ee[i][7:0];
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(8'h00, q, rsp);
    chk("ctrl", 32'h00000030, q);
    wr(8'h04, 32'h00000022, 2'h0);
    wr(8'h08, 32'h000001B7, 2'h0);
    wr(8'h0C, 32'h0000FFDC, 2'h0);
    wr(8'h10, 32'h00001B00, 2'h0);
    run(32'h00000031);
    for (i = 0; i < 22; i++) chk("ee", {24'h0, ee[i][15:8]}, {24'h0, seen[i]});
    for (i = 0; i < 11; i++) begin
      rd(ra[i], q, rsp);
      chk("row", rv[i], q);
    end
    // Slow store, coarser resolution, ignored scale nibble cleared
    dly = 3;
    u_ee.mem[8'hC0] = 8'h09;
    run(32'h00000021);
    rd(8'h18, q, rsp);
    chk("pix_oc", 32'h01E20800, q);
    rd(8'h1C, q, rsp);
    chk("grad_oc", 32'h000E3C00, q);
    rd(8'h30, q, rsp);
    chk("exps", 32'h111F2670, q);
    wr(8'h48, 32'h00000001, 2'h2);
    wr(8'h14, 32'h00000000, 2'h0);
    rd(8'h44, q, rsp);
    chk("rresp", 32'h00000002, {30'h0, rsp});
    chk("rdata", 32'h00000000, q);
    rd(8'h14, q, rsp);
    chk("status", 32'h00000002, q);
    // Second reset after a finished run clears status and restores resolution to 3
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(8'h14, q, rsp);
    chk("status_rst", 32'h00000000, q);
    rd(8'h00, q, rsp);
    chk("ctrl_rst", 32'h00000030, q);
    report_and_stop;
  end
endmodule
